// ===== verilog/pec_classifier.sv
// Two-axis error classifier core with its AXI4-Lite register slave.
//
// Overview of operation
// - Repeat nesting over fifteen or unmatched: 3008.
// - Label number out of range: global 3009.
// - Both axes in independent program: global 3010.
// - Missing completion signal after move: 4002.
// - Missing amplifier ready: local code 4003.
// - Limit input active, level configurable: 4004.
// - Absolute data read failure: local 4006.
// - Global error flags and stops both axes.
// - Local error flags only its axis.
// - Local error in simultaneous mode stops both.
// - Local error in independent mode stops one.
// - Battery low at power-up lights indicator.
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pec_cfg.svh"
module pec_classifier #(
    parameter int unsigned SVEND_WAIT_CYC = `PEC_SVEND_WAIT_MS * `PEC_CLK_KHZ
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] servo_ready_pin,
    input wire logic [1:0] pos_done_pin,
    input wire logic [1:0] limit_fwd_pin,
    input wire logic [1:0] limit_rev_pin,
    input wire logic battery_low_pin,
    input wire logic [1:0] repeat_start,
    input wire logic [1:0] repeat_end,
    input wire logic [1:0] prog_end,
    input wire logic [1:0] label_strobe,
    input wire pec_pkg::pec_code_t label_num_x,
    input wire pec_pkg::pec_code_t label_num_y,
    input wire logic [1:0] axis_conflict,
    input wire logic [1:0] move_done,
    input wire logic [1:0] absolute_position_data_fail,
    output logic [1:0] axis_stop,
    output logic [1:0] err_flag,
    output logic battery_low_indicator,
    output logic irq
);
    import pec_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [4:0] ctrl_r;
    logic [2:0] imask_r;
    logic [2:0] istat_r;
    logic aw_have_r;
    logic w_have_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic wr_fire;
    logic wr_lo;
    logic wr_map;
    logic cmd_wr;
    logic istat_wr;
    logic rd_map;
    logic [31:0] rd_nxt;
    logic [1:0] err_clr;
    logic [1:0] evt;
    logic [1:0] is_glob;
    logic [1:0] loc_hit;
    logic glob_any;
    pec_code_t glob_code;
    pec_code_t code_in [2];
    pec_code_t code_r [2];
    logic [1:0] flag_r;
    logic [1:0] stop_r;
    logic [1:0] flag_set;
    logic [1:0] stop_set;
    logic bat_s1_r;
    logic bat_s2_r;
    logic [1:0] bat_cnt_r;
    logic bat_r;
    logic bat_set;
    logic [2:0] istat_set;
    pec_code_t lbl [2];

    // ****************************************************************
    // Per-axis detectors
    // ****************************************************************
    assign lbl[0] = label_num_x;
    assign lbl[1] = label_num_y;
    assign istat_set = {bat_set, flag_set};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_axis
            pec_axis_if ax ();
            assign ax.clr = err_clr[g];
            assign ax.lim_hi = ctrl_r[`PEC_CTRL_LIMHI];
            assign ax.end_chk = ctrl_r[`PEC_CTRL_ENDCHK];
            assign ax.rdy_chk = ctrl_r[`PEC_CTRL_RDYCHK];
            assign evt[g] = ax.evt;
            assign code_in[g] = ax.code;
            pec_axis_det #(
                .WAIT_CYC(SVEND_WAIT_CYC)
            ) u_det (
                .aclk(aclk),
                .aresetn(aresetn),
                .pin_raw({limit_rev_pin[g], limit_fwd_pin[g],
                    pos_done_pin[g], servo_ready_pin[g]}),
                .repeat_start(repeat_start[g]),
                .repeat_end(repeat_end[g]),
                .prog_end(prog_end[g]),
                .label_strobe(label_strobe[g]),
                .label_num(lbl[g]),
                .axis_conflict(axis_conflict[g]),
                .move_done(move_done[g]),
                .abs_fail(absolute_position_data_fail[g]),
                .bus(ax)
            );
            // Only the two program faults that concern the whole program are global.
            assign is_glob[g] = evt[g] && (code_in[g] == `PEC_CODE_LABEL
                || code_in[g] == `PEC_CODE_AXIS);
            assign loc_hit[g] = evt[g] && !is_glob[g];
        end
    endgenerate

    // ****************************************************************
    // Classification
    // ****************************************************************
    assign glob_any = |is_glob;
    assign glob_code = is_glob[0] ? code_in[0] : code_in[1];

    always_comb begin
        for (int a = 0; a < 2; a++) begin
            // A global fault marks both axes whichever axis saw it.
            flag_set[a] = glob_any || loc_hit[a];
            if (ctrl_r[`PEC_CTRL_INDEP]) begin
                stop_set[a] = glob_any || loc_hit[a];
            end else begin
                stop_set[a] = glob_any || |loc_hit;
            end
        end
    end

    // Host reset of an error: per-axis bit, or stop command in manual mode.
    always_comb begin
        err_clr = 2'h0;
        if (cmd_wr) begin
            err_clr = wdata_r[1:0];
            if (wdata_r[`PEC_CMD_STOP] && ctrl_r[`PEC_CTRL_MANUAL]) begin
                err_clr = 2'h3;
            end
        end
    end

    // A fault still present at the reset sets again, so set wins over clear.
    generate
        for (g = 0; g < 2; g++) begin : g_hold
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    code_r[g] <= `PEC_CODE_NONE;
                    flag_r[g] <= 1'b0;
                end else if (flag_set[g]) begin
                    code_r[g] <= glob_any ? glob_code : code_in[g];
                    flag_r[g] <= 1'b1;
                end else if (err_clr[g]) begin
                    code_r[g] <= `PEC_CODE_NONE;
                    flag_r[g] <= 1'b0;
                end
            end

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    stop_r[g] <= 1'b0;
                end else if (stop_set[g]) begin
                    stop_r[g] <= 1'b1;
                end else if (err_clr[g]) begin
                    stop_r[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign axis_stop = stop_r;
    assign err_flag = flag_r;

    // ****************************************************************
    // Battery check at power-up
    // ****************************************************************
    always_ff @(posedge aclk) begin
        bat_s1_r <= battery_low_pin;
        bat_s2_r <= bat_s1_r;
    end

    // The level is taken once the synchroniser has filled after reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bat_cnt_r <= 2'h0;
        end else if (bat_cnt_r != 2'h3) begin
            bat_cnt_r <= bat_cnt_r + 2'h1;
        end
    end

    assign bat_set = bat_cnt_r == `PEC_BATTERY_LOW_INDICATOR_SETTLE && bat_s2_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bat_r <= 1'b0;
        end else if (bat_set) begin
            bat_r <= 1'b1;
        end
    end

    assign battery_low_indicator = bat_r;

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            istat_r <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (istat_set[i]) begin
                    istat_r[i] <= 1'b1;
                end else if (istat_wr && wdata_r[i]) begin
                    istat_r[i] <= 1'b0;
                end
            end
        end
    end

    assign irq = |(istat_r & imask_r);

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    assign s_axi_awready = !aw_have_r;
    assign s_axi_wready = !w_have_r;
    assign wr_fire = aw_have_r && w_have_r && !bvalid_r;
    assign wr_lo = wr_fire && wstrb_r[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            awaddr_r <= 8'h00;
        end else if (s_axi_awvalid && !aw_have_r) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_r <= 1'b0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid && !w_have_r) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_have_r <= 1'b0;
        end
    end

    always_comb begin
        case (awaddr_r)
            `PEC_OFF_CTRL, `PEC_OFF_CMD, `PEC_OFF_ERRX, `PEC_OFF_ERRY,
            `PEC_OFF_STAT, `PEC_OFF_ISTAT, `PEC_OFF_IMASK: wr_map = 1'b1;
            default: wr_map = 1'b0;
        endcase
    end

    assign cmd_wr = wr_lo && awaddr_r == `PEC_OFF_CMD;
    assign istat_wr = wr_lo && awaddr_r == `PEC_OFF_ISTAT;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `PEC_CTRL_RST;
        end else if (wr_lo && awaddr_r == `PEC_OFF_CTRL) begin
            ctrl_r <= wdata_r[4:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            imask_r <= 3'h0;
        end else if (wr_lo && awaddr_r == `PEC_OFF_IMASK) begin
            imask_r <= wdata_r[2:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= `PEC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_map ? `PEC_RESP_OKAY : `PEC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    assign s_axi_arready = !rvalid_r;

    always_comb begin
        rd_map = 1'b1;
        case (s_axi_araddr)
            `PEC_OFF_CTRL: rd_nxt = {27'h0, ctrl_r};
            `PEC_OFF_CMD: rd_nxt = 32'h0;
            `PEC_OFF_ERRX: rd_nxt = {15'h0, flag_r[0], code_r[0]};
            `PEC_OFF_ERRY: rd_nxt = {15'h0, flag_r[1], code_r[1]};
            `PEC_OFF_STAT: rd_nxt = {27'h0, flag_r, bat_r, stop_r};
            `PEC_OFF_ISTAT: rd_nxt = {29'h0, istat_r};
            `PEC_OFF_IMASK: rd_nxt = {29'h0, imask_r};
            default: begin
                rd_nxt = 32'h0;
                rd_map = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= `PEC_RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_nxt;
            rresp_r <= rd_map ? `PEC_RESP_OKAY : `PEC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
endmodule // pec_classifier

// ===== verilog/pec_cfg.svh
// Offsets, fields, reset values, error codes and timing of the classifier.
`ifndef PEC_CFG_SVH
`define PEC_CFG_SVH
`define PEC_OFF_CTRL 8'h00
`define PEC_OFF_CMD 8'h04
`define PEC_OFF_ERRX 8'h08
`define PEC_OFF_ERRY 8'h0C
`define PEC_OFF_STAT 8'h10
`define PEC_OFF_ISTAT 8'h14
`define PEC_OFF_IMASK 8'h18
`define PEC_CTRL_INDEP 0
`define PEC_CTRL_LIMHI 1
`define PEC_CTRL_ENDCHK 2
`define PEC_CTRL_RDYCHK 3
`define PEC_CTRL_MANUAL 4
`define PEC_CTRL_RST 5'h0C
`define PEC_CMD_STOP 2
`define PEC_ERR_FLAG 16
`define PEC_IRQ_BATTERY_LOW_INDICATOR 2
`define PEC_CODE_NONE 16'h0000
`define PEC_CODE_REPEAT 16'h3008
`define PEC_CODE_LABEL 16'h3009
`define PEC_CODE_AXIS 16'h3010
`define PEC_CODE_SVEND 16'h4002
`define PEC_CODE_SVRDY 16'h4003
`define PEC_CODE_LIMIT 16'h4004
`define PEC_CODE_ABS 16'h4006
`define PEC_REPEAT_MAX 5'h0F
`define PEC_LABEL_MAX 16'h00FF
`define PEC_CLK_KHZ 20000
`define PEC_SVEND_WAIT_MS 10
`define PEC_BATTERY_LOW_INDICATOR_SETTLE 2'h2
`define PEC_RESP_OKAY 2'h0
`define PEC_RESP_SLVERR 2'h2
`endif

// ===== verilog/pec_pkg.sv
// Types shared by the classifier modules.
package pec_pkg;
    typedef logic [15:0] pec_code_t;
    typedef enum logic {PEC_SVEND_IDLE, PEC_SVEND_WAIT} pec_svend_t;
endpackage

// ===== verilog/pec_axis_if.sv
// Carrier between one axis detector and the classifier core.
`timescale 1ns/1ps
interface pec_axis_if;
    import pec_pkg::*;
    logic evt;
    pec_code_t code;
    logic clr;
    logic lim_hi;
    logic end_chk;
    logic rdy_chk;
    modport det (
        output evt,
        output code,
        input clr,
        input lim_hi,
        input end_chk,
        input rdy_chk
    );
    modport cls (
        input evt,
        input code,
        output clr,
        output lim_hi,
        output end_chk,
        output rdy_chk
    );
endinterface

// ===== verilog/pec_axis_det.sv
// Per-axis fault detector for program and amplifier faults.
`timescale 1ns/1ps
`include "pec_cfg.svh"
module pec_axis_det #(
    parameter int unsigned WAIT_CYC = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] pin_raw,
    input wire logic repeat_start,
    input wire logic repeat_end,
    input wire logic prog_end,
    input wire logic label_strobe,
    input wire pec_pkg::pec_code_t label_num,
    input wire logic axis_conflict,
    input wire logic move_done,
    input wire logic abs_fail,
    pec_axis_if.det bus
);
    import pec_pkg::*;
    // Pin order: 0 ready, 1 completion, 2 forward limit, 3 reverse limit.
    logic [3:0] pin_s1_r;
    logic [3:0] pin_s2_r;
    logic [4:0] depth_r;
    logic rpt_fault;
    logic lim_act;
    logic svend_fault;
    pec_svend_t svend_r;
    logic [31:0] wait_r;

    always_ff @(posedge aclk) begin
        pin_s1_r <= pin_raw;
        pin_s2_r <= pin_s1_r;
    end

    always_comb begin
        rpt_fault = 1'b0;
        if (repeat_start && depth_r == `PEC_REPEAT_MAX) begin
            rpt_fault = 1'b1;
        end
        if (repeat_end && depth_r == 5'h00) begin
            rpt_fault = 1'b1;
        end
        if (prog_end && depth_r != 5'h00) begin
            rpt_fault = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || bus.clr || prog_end) begin
            depth_r <= 5'h00;
        end else if (repeat_start && !rpt_fault) begin
            depth_r <= depth_r + 5'h01;
        end else if (repeat_end && !rpt_fault) begin
            depth_r <= depth_r - 5'h01;
        end
    end

    // The first two wait cycles still show the completion pin from before the move ended.
    always_ff @(posedge aclk) begin
        if (!aresetn || bus.clr) begin
            svend_r <= PEC_SVEND_IDLE;
            wait_r <= 32'h0;
        end else begin
            case (svend_r)
                PEC_SVEND_IDLE: begin
                    if (move_done && bus.end_chk) begin
                        svend_r <= PEC_SVEND_WAIT;
                        wait_r <= 32'h0;
                    end
                end
                PEC_SVEND_WAIT: begin
                    wait_r <= wait_r + 32'h1;
                    if ((pin_s2_r[1] && wait_r >= 32'h2) || svend_fault) begin
                        svend_r <= PEC_SVEND_IDLE;
                    end
                end
                default: svend_r <= PEC_SVEND_IDLE;
            endcase
        end
    end

    assign svend_fault = svend_r == PEC_SVEND_WAIT && !pin_s2_r[1]
        && wait_r >= WAIT_CYC - 1;
    assign lim_act = bus.lim_hi ? (pin_s2_r[2] | pin_s2_r[3])
        : ~(pin_s2_r[2] & pin_s2_r[3]);

    always_comb begin
        bus.evt = 1'b1;
        if (abs_fail) begin
            bus.code = `PEC_CODE_ABS;
        end else if (lim_act) begin
            bus.code = `PEC_CODE_LIMIT;
        end else if (bus.rdy_chk && !pin_s2_r[0]) begin
            bus.code = `PEC_CODE_SVRDY;
        end else if (svend_fault) begin
            bus.code = `PEC_CODE_SVEND;
        end else if (axis_conflict) begin
            bus.code = `PEC_CODE_AXIS;
        end else if (label_strobe && label_num > `PEC_LABEL_MAX) begin
            bus.code = `PEC_CODE_LABEL;
        end else if (rpt_fault) begin
            bus.code = `PEC_CODE_REPEAT;
        end else begin
            bus.evt = 1'b0;
            bus.code = `PEC_CODE_NONE;
        end
    end
endmodule // pec_axis_det

// ===== dv/pec_classifier_properties.sv
// Concurrent checks on the ports of the error classifier.
`timescale 1ns/1ps
`include "pec_cfg.svh"
module pec_classifier_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [1:0] servo_ready_pin,
    input wire logic [1:0] label_strobe,
    input wire pec_pkg::pec_code_t label_num_y,
    input wire logic [1:0] axis_conflict,
    input wire logic [1:0] absolute_position_data_fail,
    input wire logic [1:0] axis_stop,
    input wire logic [1:0] err_flag,
    input wire logic battery_low_indicator
);
    import pec_pkg::*;
    // ****************
    // Checks
    // ****************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence aw_w_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Three idle data cycles let any pending clear land before the flag is judged.
    sequence w_idle;
        !s_axi_wvalid [*3];
    endsequence
    chk_write_answer: assert property (aw_w_take |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    chk_abs_flag: assert property (absolute_position_data_fail[0] |=> err_flag[0])
        else $error("absolute data fault not flagged");
    chk_abs_stop: assert property (absolute_position_data_fail[0] |=> axis_stop[0])
        else $error("absolute data fault did not stop axis");
    chk_label_global: assert property (label_strobe[1] && label_num_y > `PEC_LABEL_MAX
        |=> err_flag == 2'h3 && axis_stop == 2'h3) else $error("label fault not global");
    chk_conflict_global: assert property (axis_conflict[1]
        |=> err_flag == 2'h3 && axis_stop == 2'h3) else $error("axis fault not global");
    chk_ready_local: assert property ($fell(servo_ready_pin[0]) |-> ##[2:4] err_flag[0])
        else $error("ready fault not flagged");
    chk_battery_low_indicator_sticky: assert property (battery_low_indicator |=> battery_low_indicator)
        else $error("battery indicator dropped");
    chk_flag_holds: assert property (w_idle ##0 err_flag[0] |=> err_flag[0])
        else $error("error flag cleared without a write");
endmodule // pec_classifier_chk
bind pec_classifier pec_classifier_chk pec_classifier_chk_inst (.*);

// ===== dv/pec_amp_model.sv
// Behavioural model of the two amplifiers and the limit inputs.
`timescale 1ns/1ps
module pec_amp_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] move_done,
    input wire logic [1:0] ready_ok,
    input wire logic [1:0] lim_act,
    input wire logic lim_hi,
    input wire logic [7:0] done_dly,
    input wire logic battery_low_indicator_low,
    output logic [1:0] servo_ready_pin,
    output logic [1:0] pos_done_pin,
    output logic [1:0] limit_fwd_pin,
    output logic [1:0] limit_rev_pin,
    output logic battery_low_pin
);
    logic [7:0] cnt_r [2];
    assign servo_ready_pin = ready_ok;
    assign limit_fwd_pin = lim_hi ? lim_act : ~lim_act;
    assign limit_rev_pin = {2{~lim_hi}};
    assign battery_low_pin = battery_low_indicator_low;
    // A delay of 8'hFF is an amplifier that never reports completion.
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 2; i++) begin
            if (!aresetn || move_done[i]) begin
                cnt_r[i] <= aresetn ? done_dly : 8'h00;
                pos_done_pin[i] <= 1'h0;
            end else if (cnt_r[i] == 8'h00) begin
                pos_done_pin[i] <= 1'h1;
            end else if (cnt_r[i] != 8'hFF) begin
                cnt_r[i] <= cnt_r[i] - 8'h01;
            end
        end
    end
endmodule // pec_amp_model

// ===== dv/tb_top.sv
// Self-checking bench for the error classifier.
`timescale 1ns/1ps
`include "pec_cfg.svh"
module tb_top;
    import pec_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, axis_stop, err_flag;
    logic [1:0] servo_ready_pin, pos_done_pin, limit_fwd_pin, limit_rev_pin;
    logic battery_low_pin, battery_low_indicator, irq, lim_hi = 1'h0;
    logic [1:0] repeat_start = 2'h0, repeat_end = 2'h0, prog_end = 2'h0, label_strobe = 2'h0;
    logic [1:0] axis_conflict = 2'h0, move_done = 2'h0, absolute_position_data_fail = 2'h0;
    logic [1:0] ready_ok = 2'h3, lim_act = 2'h0;
    logic [7:0] done_dly = 8'h02;
    pec_code_t label_num_x = 16'h0000, label_num_y = 16'h0000;
    int err_count = 0, checks = 0;
    initial begin
        forever #25 aclk = ~aclk;
    end
    pec_classifier #(.SVEND_WAIT_CYC(8)) pec_classifier_inst (.*);
    pec_amp_model pec_amp_model_inst (.*, .battery_low_indicator_low(1'h1));
    // ****************
    // Bus tasks
    // ****************
    task chk(input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, er);
    endtask
    task rd(input logic [7:0] a, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        rv = s_axi_rdata;
        chk(s_axi_rresp, er);
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e);
        rd(a, `PEC_RESP_OKAY);
        chk(rv, e);
    endtask
    task errs(input logic [31:0] ex, ey, input logic [1:0] st);
        rc(`PEC_OFF_ERRX, ex);
        rc(`PEC_OFF_ERRY, ey);
        chk(axis_stop, st);
    endtask
    task clr;
        wr(`PEC_OFF_CMD, 32'h3, `PEC_RESP_OKAY);
        wr(`PEC_OFF_ISTAT, 32'h7, `PEC_RESP_OKAY);
    endtask
    task stop_test;
        $display("Checks %0d, errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // The whole sequence needs about three hundred cycles.
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        stop_test();
    end
    // ****************
    // Tests
    // ****************
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        rc(`PEC_OFF_CTRL, {27'h0, `PEC_CTRL_RST});
        rc(`PEC_OFF_IMASK, 32'h0);
        rc(`PEC_OFF_ERRX, 32'h0);
        rc(`PEC_OFF_STAT, 32'h4);
        chk(battery_low_indicator, 32'h1);
        rd(8'h1C, `PEC_RESP_SLVERR);
        chk(rv, 32'h0);
        wr(8'h1C, 32'hFFFFFFFF, `PEC_RESP_SLVERR);
        @(posedge aclk) absolute_position_data_fail <= 2'h1;
        @(posedge aclk) absolute_position_data_fail <= 2'h0;
        errs(32'h14006, 32'h0, 2'h3);
        rc(`PEC_OFF_ISTAT, 32'h5);
        chk(irq, 32'h0);
        wr(`PEC_OFF_IMASK, 32'h1, `PEC_RESP_OKAY);
        #1 chk(irq, 32'h1);
        clr();
        #1 chk(irq, 32'h0);
        errs(32'h0, 32'h0, 2'h0);
        wr(`PEC_OFF_CTRL, 32'h0D, `PEC_RESP_OKAY);
        @(posedge aclk) lim_act <= 2'h2;
        errs(32'h0, 32'h14004, 2'h2);
        wr(`PEC_OFF_CMD, 32'h2, `PEC_RESP_OKAY);
        errs(32'h0, 32'h14004, 2'h2);
        @(posedge aclk) lim_act <= 2'h0;
        repeat (4) @(posedge aclk);
        wr(`PEC_OFF_CMD, 32'h3, `PEC_RESP_OKAY);
        errs(32'h0, 32'h0, 2'h0);
        @(posedge aclk) ready_ok <= 2'h2;
        repeat (2) @(posedge aclk);
        errs(32'h14003, 32'h0, 2'h1);
        @(posedge aclk) ready_ok <= 2'h3;
        repeat (4) @(posedge aclk);
        clr();
        @(posedge aclk) move_done <= 2'h1;
        @(posedge aclk) move_done <= 2'h0;
        repeat (20) @(posedge aclk);
        rc(`PEC_OFF_ERRX, 32'h0);
        @(posedge aclk) move_done <= 2'h1;
        done_dly <= 8'hFF;
        @(posedge aclk) move_done <= 2'h0;
        repeat (20) @(posedge aclk);
        errs(32'h14002, 32'h0, 2'h1);
        clr();
        repeat (15) begin
            @(posedge aclk) repeat_start <= 2'h1;
            @(posedge aclk) repeat_start <= 2'h0;
        end
        rc(`PEC_OFF_ERRX, 32'h0);
        @(posedge aclk) repeat_start <= 2'h1;
        @(posedge aclk) repeat_start <= 2'h0;
        errs(32'h13008, 32'h0, 2'h1);
        clr();
        @(posedge aclk) label_num_y <= `PEC_LABEL_MAX;
        label_strobe <= 2'h2;
        @(posedge aclk) label_strobe <= 2'h0;
        rc(`PEC_OFF_ERRY, 32'h0);
        @(posedge aclk) label_num_y <= `PEC_LABEL_MAX + 16'h0001;
        label_strobe <= 2'h2;
        @(posedge aclk) label_strobe <= 2'h0;
        errs(32'h13009, 32'h13009, 2'h3);
        clr();
        @(posedge aclk) axis_conflict <= 2'h2;
        @(posedge aclk) axis_conflict <= 2'h0;
        errs(32'h13010, 32'h13010, 2'h3);
        clr();
        @(posedge aclk) absolute_position_data_fail <= 2'h2;
        @(posedge aclk) absolute_position_data_fail <= 2'h0;
        wr(`PEC_OFF_CMD, 32'h4, `PEC_RESP_OKAY);
        errs(32'h0, 32'h14006, 2'h2);
        wr(`PEC_OFF_CTRL, 32'h1D, `PEC_RESP_OKAY);
        wr(`PEC_OFF_CMD, 32'h4, `PEC_RESP_OKAY);
        errs(32'h0, 32'h0, 2'h0);
        @(posedge aclk) lim_hi <= 1'h1;
        wr(`PEC_OFF_CTRL, 32'h0F, `PEC_RESP_OKAY);
        repeat (4) @(posedge aclk);
        clr();
        errs(32'h0, 32'h0, 2'h0);
        @(posedge aclk) lim_act <= 2'h1;
        repeat (2) @(posedge aclk);
        errs(32'h14004, 32'h0, 2'h1);
        stop_test();
    end
endmodule // tb_top
